/* pcc_chan_seq.sv */
`timescale 1ns/1ns
module pcc_chan_seq (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ms_tick,
  // commands and options
  input wire logic cmd_on,
  input wire logic short_cyc_en,
  input wire logic no_run_pulse,
  input wire logic share_guard,
  input wire logic share_low,
  input wire logic [15:0] off_delay_ms,
  input wire logic [15:0] fall_ms,
  input wire logic [15:0] restart_ms,
  // status
  output logic out_en,
  output logic run_oe_b,
  output logic operating
);
  import pcc_pkg::*;

  pcc_seq_state_t q_reg, q_next;
  logic [17:0] pulse_len;

  always_comb begin
    pulse_len = 18'(off_delay_ms) + 18'(fall_ms) + RUN_PAD_MS;
    if (18'(restart_ms) > pulse_len) begin
      pulse_len = 18'(restart_ms);
    end
    q_next = q_reg;
    if (ms_tick && q_reg.tmr != '0) begin
      q_next.tmr = q_reg.tmr - 18'h00001;
    end
    if (ms_tick && q_reg.run_tmr != '0) begin
      q_next.run_tmr = q_reg.run_tmr - 18'h00001;
    end
    unique case (q_reg.st)
      PCC_SQ_OFF: begin
        if (cmd_on) begin
          q_next.st = PCC_SQ_ON;
        end
      end
      PCC_SQ_ON: begin
        if (!cmd_on) begin
          q_next.st = PCC_SQ_DELAY;
          q_next.tmr = 18'(off_delay_ms);
          // pulse starts whatever the short-cycle bit holds
          if (!no_run_pulse) begin
            q_next.run_tmr = pulse_len;
          end
        end
      end
      PCC_SQ_DELAY, PCC_SQ_FALL: begin
        if (cmd_on) begin
          if (short_cyc_en) begin
            q_next.st = PCC_SQ_HOLD;
            q_next.tmr = MIN_OFF_MS + 18'h00001;
          end else begin
            q_next.st = PCC_SQ_ON;
          end
        end else if (q_reg.tmr == '0) begin
          if (q_reg.st == PCC_SQ_DELAY) begin
            q_next.st = PCC_SQ_FALL;
            q_next.tmr = 18'(fall_ms);
          end else begin
            q_next.st = PCC_SQ_OFF;
          end
        end
      end
      PCC_SQ_HOLD: begin
        // hold lasts until both the minimum off time and the run pulse have ended
        if (q_reg.tmr == '0 && (no_run_pulse || q_reg.run_tmr == '0)) begin
          q_next.st = PCC_SQ_OFF;
        end
      end
    endcase
    q_next.operating = q_next.st inside {PCC_SQ_ON, PCC_SQ_DELAY, PCC_SQ_FALL};
    q_next.out_en = q_next.operating && !(share_guard && share_low);
    q_next.run_oe_b = (q_next.run_tmr == '0);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= '{st: PCC_SQ_OFF, tmr: '0, run_tmr: '0, out_en: 1'b0,
                 run_oe_b: 1'b1, operating: 1'b0};
    end else begin
      q_reg <= q_next;
    end
  end

  assign out_en = q_reg.out_en;
  assign run_oe_b = q_reg.run_oe_b;
  assign operating = q_reg.operating;

endmodule // pcc_chan_seq

/* pcc_config.sv */
`timescale 1ns/1ns
// Functional notes
// - one frequency drives every pwm channel
// - free-run when sync absent or stuck
// - busy nack while either master runs
// - pll unlocked shown while frequency settles
// - frequency is two-byte linear word
// - bit 5 page 0 picks sense function
// - bit 4 clear pulses run pin low
// - bit 4 set leaves run pin alone
// - bit 3 clear follows commands exactly
// - bit 3 set: abort, 120ms off
// - hold waits for both run pulse and minimum off
// - bit 2 gates output on timebase low
module pcc_config #(
  parameter logic [6:0] DEV_ADDR = 7'h40,
  parameter int MS_TICK_CYCLES = pcc_pkg::MS_CYCLES,
  parameter int SYNC_LOSS = pcc_pkg::SYNC_LOSS_CYCLES,
  parameter int PLL_SETTLE = pcc_pkg::PLL_SETTLE_MS
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // pmbus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_b,
  // channel commands and timing settings
  input wire logic [pcc_pkg::NUM_CH-1:0] chan_on_cmd,
  input wire logic [pcc_pkg::NUM_CH-1:0][15:0] off_delay_ms,
  input wire logic [pcc_pkg::NUM_CH-1:0][15:0] fall_ms,
  input wire logic [pcc_pkg::NUM_CH-1:0][15:0] restart_ms,
  // timebase pins
  input wire logic shared_timebase_line_i,
  input wire logic sync_i,
  input wire logic ext_clk_expected,
  // channel outputs
  output logic [pcc_pkg::NUM_CH-1:0] chan_out_en,
  output logic [pcc_pkg::NUM_CH-1:0] run_o,
  output logic [pcc_pkg::NUM_CH-1:0] run_oe_b,
  // configuration and status
  output logic [10:0] pwm_freq_khz,
  output logic pwm_free_run,
  output logic pll_unlocked,
  output logic busy_fault,
  output logic sense_is_drv_mon,
  output logic [7:0] phase_arrangement_byte
);
  import pcc_pkg::*;

  typedef struct packed {
    pcc_bus_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic [7:0] cmd;
    logic [1:0] bytecnt;
    logic [7:0] freq_lo;
    logic sda_oe_b;
    logic page;
    logic [15:0] freq;
    logic [10:0] freq_khz;
    logic [NUM_CH-1:0][7:0] opt;
    logic [7:0] phase;
    logic [7:0] pll_cnt;
    logic pll_unlocked;
    logic busy_pulse;
    logic [15:0] ms_div;
    logic ms_tick;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] sync_s;
    logic [1:0] share_s;
    logic [15:0] sync_wd;
    logic free_run;
    logic drv_mon;
  } pcc_top_t;

  pcc_top_t q_reg, q_next;
  logic [NUM_CH-1:0] operating;
  logic any_on;

  // ************************************************************
  // helpers
  // ************************************************************
  // signed exponent and mantissa to plain kilohertz
  function automatic logic [10:0] l11_to_khz(input logic [15:0] w);
    logic signed [4:0] e;
    logic signed [31:0] v;
    e = w[L11_EXP_MSB:L11_EXP_LSB];
    v = 32'(signed'(w[L11_MANT_MSB:0]));
    if (e < 0) begin
      v = v >>> (-int'(e));
    end else begin
      v = v <<< int'(e);
    end
    return v[10:0];
  endfunction

  function automatic logic [7:0] read_byte(input pcc_top_t s, input logic [1:0] idx);
    logic [7:0] b;
    b = READ_FILL;
    unique case (s.cmd)
      CMD_PAGE: b = {7'h00, s.page};
      CMD_FREQ: b = (idx == 2'h0) ? s.freq[7:0] : s.freq[15:8];
      CMD_CHAN_OPT: b = s.opt[s.page];
      CMD_PHASE: b = s.phase;
      default: b = READ_FILL;
    endcase
    return b;
  endfunction

  function automatic logic needs_idle(input logic [7:0] c);
    return (c == CMD_FREQ) || (c == CMD_PHASE);
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic scl_rise, scl_fall, bus_start, bus_stop, sda_now;
    logic [7:0] rx;
    q_next = q_reg;
    q_next.busy_pulse = 1'b0;
    q_next.ms_tick = 1'b0;
    // two flops before any logic looks at scl, sda, sync or the shared timebase pin
    q_next.scl_s = {q_reg.scl_s[1:0], scl_i};
    q_next.sda_s = {q_reg.sda_s[1:0], sda_i};
    q_next.sync_s = {q_reg.sync_s[1:0], sync_i};
    q_next.share_s = {q_reg.share_s[0], shared_timebase_line_i};
    sda_now = q_reg.sda_s[1];
    scl_rise = q_reg.scl_s[1] && !q_reg.scl_s[2];
    scl_fall = !q_reg.scl_s[1] && q_reg.scl_s[2];
    bus_start = q_reg.scl_s[1] && q_reg.scl_s[2] && q_reg.sda_s[2] && !sda_now;
    bus_stop = q_reg.scl_s[1] && q_reg.scl_s[2] && !q_reg.sda_s[2] && sda_now;
    rx = {q_reg.shreg[6:0], sda_now};

    if (q_reg.ms_div == 16'(MS_TICK_CYCLES - 1)) begin
      q_next.ms_div = '0;
      q_next.ms_tick = 1'b1;
    end else begin
      q_next.ms_div = q_reg.ms_div + 16'h0001;
    end

    // watchdog on the sync line catches both loss and stuck level
    if (q_reg.sync_s[1] != q_reg.sync_s[2]) begin
      q_next.sync_wd = '0;
    end else if (q_reg.sync_wd != 16'(SYNC_LOSS)) begin
      q_next.sync_wd = q_reg.sync_wd + 16'h0001;
    end
    q_next.free_run = !ext_clk_expected || (q_reg.sync_wd == 16'(SYNC_LOSS));

    if (q_reg.ms_tick && q_reg.pll_cnt != '0) begin
      q_next.pll_cnt = q_reg.pll_cnt - 8'h01;
    end
    q_next.pll_unlocked = (q_next.pll_cnt != '0);
    q_next.drv_mon = q_reg.opt[0][OPT_DRV_MON_BIT];

    if (bus_start) begin
      q_next.st = PCC_ADDR;
      q_next.bitcnt = '0;
      q_next.bytecnt = '0;
      q_next.sda_oe_b = 1'b1;
    end else if (bus_stop) begin
      q_next.st = PCC_IDLE;
      q_next.sda_oe_b = 1'b1;
    end else begin
      unique case (q_reg.st)
        PCC_IDLE, PCC_IGNORE: begin
          q_next.sda_oe_b = 1'b1;
        end
        PCC_ADDR, PCC_CMD, PCC_WDATA: begin
          if (scl_rise) begin
            q_next.shreg = rx;
            q_next.bitcnt = q_reg.bitcnt + 4'h1;
          end else if (scl_fall && q_reg.bitcnt == 4'(BYTE_BITS)) begin
            q_next.bitcnt = '0;
            if (q_reg.st == PCC_ADDR) begin
              if (q_reg.shreg[7:1] == DEV_ADDR) begin
                q_next.rw = q_reg.shreg[0];
                q_next.sda_oe_b = 1'b0;
                q_next.st = PCC_ADDR_ACK;
              end else begin
                q_next.st = PCC_IGNORE;
              end
            end else if (q_reg.st == PCC_CMD) begin
              q_next.cmd = q_reg.shreg;
              if (needs_idle(q_reg.shreg) && any_on) begin
                // nack the command byte, drop its data
                q_next.busy_pulse = 1'b1;
                q_next.st = PCC_IGNORE;
              end else if (q_reg.shreg inside {CMD_PAGE, CMD_FREQ, CMD_CHAN_OPT, CMD_PHASE}) begin
                q_next.sda_oe_b = 1'b0;
                q_next.st = PCC_CMD_ACK;
              end else begin
                q_next.st = PCC_IGNORE;
              end
            end else begin
              q_next.sda_oe_b = 1'b0;
              q_next.st = PCC_WDATA_ACK;
              q_next.bytecnt = q_reg.bytecnt + 2'h1;
              unique case (q_reg.cmd)
                CMD_PAGE: begin
                  if (q_reg.bytecnt == 2'h0 && q_reg.shreg[7:1] == 7'h00) begin
                    q_next.page = q_reg.shreg[0];
                  end
                end
                CMD_FREQ: begin
                  if (q_reg.bytecnt == 2'h0) begin
                    q_next.freq_lo = q_reg.shreg;
                  end else if (q_reg.bytecnt == 2'h1) begin
                    q_next.freq = {q_reg.shreg, q_reg.freq_lo};
                    q_next.freq_khz = l11_to_khz({q_reg.shreg, q_reg.freq_lo});
                    q_next.pll_cnt = 8'(PLL_SETTLE);
                  end
                end
                CMD_CHAN_OPT: begin
                  if (q_reg.bytecnt == 2'h0) begin
                    q_next.opt[q_reg.page] = q_reg.shreg;
                  end
                end
                CMD_PHASE: begin
                  if (q_reg.bytecnt == 2'h0) begin
                    q_next.phase = q_reg.shreg;
                  end
                end
                default: begin
                  q_next.sda_oe_b = 1'b1;
                  q_next.st = PCC_IGNORE;
                end
              endcase
            end
          end
        end
        PCC_ADDR_ACK, PCC_CMD_ACK, PCC_WDATA_ACK: begin
          if (scl_fall) begin
            q_next.sda_oe_b = 1'b1;
            q_next.bitcnt = '0;
            q_next.st = (q_reg.st == PCC_ADDR_ACK) ? PCC_CMD : PCC_WDATA;
            if (q_reg.st == PCC_ADDR_ACK && q_reg.rw) begin
              q_next.shreg = read_byte(q_reg, q_reg.bytecnt);
              q_next.sda_oe_b = q_next.shreg[7];
              q_next.bitcnt = 4'h1;
              q_next.st = PCC_RDATA;
            end
          end
        end
        PCC_RDATA: begin
          if (scl_fall) begin
            if (q_reg.bitcnt == 4'(BYTE_BITS)) begin
              q_next.sda_oe_b = 1'b1;
              q_next.st = PCC_RDATA_ACK;
            end else begin
              q_next.shreg = {q_reg.shreg[6:0], 1'b0};
              q_next.sda_oe_b = q_reg.shreg[6];
              q_next.bitcnt = q_reg.bitcnt + 4'h1;
            end
          end
        end
        PCC_RDATA_ACK: begin
          if (scl_rise && sda_now) begin
            q_next.st = PCC_IGNORE;
          end else if (scl_fall) begin
            q_next.bytecnt = q_reg.bytecnt + 2'h1;
            q_next.shreg = read_byte(q_reg, q_reg.bytecnt + 2'h1);
            q_next.sda_oe_b = q_next.shreg[7];
            q_next.bitcnt = 4'h1;
            q_next.st = PCC_RDATA;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= '0;
      q_reg.st <= PCC_IDLE;
      q_reg.sda_oe_b <= 1'b1;
      q_reg.freq <= FREQ_RST;
      q_reg.freq_khz <= FREQ_KHZ_RST;
      q_reg.opt <= {NUM_CH{OPT_RST}};
      q_reg.phase <= PHASE_RST;
      q_reg.scl_s <= 3'h7;
      q_reg.sda_s <= 3'h7;
      q_reg.share_s <= 2'h3;
    end else begin
      q_reg <= q_next;
    end
  end

  // ************************************************************
  // channels
  // ************************************************************
  assign any_on = |operating;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
    pcc_chan_seq u_seq (
      .clock(clock),
      .rst_b(rst_b),
      .ms_tick(q_reg.ms_tick),
      .cmd_on(chan_on_cmd[ch]),
      .short_cyc_en(q_reg.opt[ch][OPT_SHORT_CYC_BIT]),
      .no_run_pulse(q_reg.opt[ch][OPT_NO_RUN_PULSE_BIT]),
      .share_guard(q_reg.opt[ch][OPT_SHARE_GUARD_BIT]),
      .share_low(!q_reg.share_s[1]),
      .off_delay_ms(off_delay_ms[ch]),
      .fall_ms(fall_ms[ch]),
      .restart_ms(restart_ms[ch]),
      .out_en(chan_out_en[ch]),
      .run_oe_b(run_oe_b[ch]),
      .operating(operating[ch])
    );
  end

  // open-drain pins only ever drive low
  assign sda_o = 1'b0;
  assign run_o = '0;
  assign sda_oe_b = q_reg.sda_oe_b;
  assign pwm_freq_khz = q_reg.freq_khz;
  assign pwm_free_run = q_reg.free_run;
  assign pll_unlocked = q_reg.pll_unlocked;
  assign busy_fault = q_reg.busy_pulse;
  assign sense_is_drv_mon = q_reg.drv_mon;
  assign phase_arrangement_byte = q_reg.phase;

endmodule // pcc_config

/* pcc_config_asserts.sv */
`timescale 1ns/1ns
module pcc_config_asserts #(
  parameter int MS_TICK_CYCLES = pcc_pkg::MS_CYCLES,
  parameter int SYNC_LOSS = pcc_pkg::SYNC_LOSS_CYCLES,
  parameter int PLL_SETTLE = pcc_pkg::PLL_SETTLE_MS
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // watched pins
  input wire logic [pcc_pkg::NUM_CH-1:0] chan_on_cmd,
  input wire logic [pcc_pkg::NUM_CH-1:0][15:0] off_delay_ms,
  input wire logic [pcc_pkg::NUM_CH-1:0][15:0] fall_ms,
  input wire logic [pcc_pkg::NUM_CH-1:0][15:0] restart_ms,
  input wire logic sync_i,
  input wire logic ext_clk_expected,
  input wire logic [pcc_pkg::NUM_CH-1:0] chan_out_en,
  input wire logic [pcc_pkg::NUM_CH-1:0] run_oe_b,
  input wire logic [10:0] pwm_freq_khz,
  input wire logic pwm_free_run,
  input wire logic pll_unlocked,
  input wire logic busy_fault,
  input wire logic [7:0] phase_arrangement_byte
);
  import pcc_pkg::*;
  int run_max, pll_cnt, sync_cnt, run_cnt, off_cnt;
  always_comb begin
    run_max = int'(off_delay_ms[0]) + int'(fall_ms[0]) + int'(RUN_PAD_MS);
    if (int'(restart_ms[0]) > run_max) run_max = int'(restart_ms[0]);
  end
  // ****************
  // helper counters
  // ****************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pll_cnt <= 0;
      sync_cnt <= 0;
      run_cnt <= 0;
      off_cnt <= 0;
    end else begin
      pll_cnt <= pll_unlocked ? pll_cnt + 1 : 0;
      sync_cnt <= $changed(sync_i) ? 0 : sync_cnt + 1;
      run_cnt <= run_oe_b[0] ? 0 : run_cnt + 1;
      off_cnt <= (!chan_on_cmd[0] && chan_out_en[0]) ? off_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_busy;
    busy_fault;
  endsequence
  sequence s_run_start;
    $fell(run_oe_b[0]);
  endsequence
  property p_busy_pulse;
    s_busy |=> !busy_fault;
  endproperty
  property p_busy_keep;
    s_busy |-> ($stable(pwm_freq_khz) && $stable(phase_arrangement_byte)) [*8];
  endproperty
  property p_pll_on;
    $changed(pwm_freq_khz) |-> ##[0:1] pll_unlocked;
  endproperty
  property p_pll_len;
    pll_cnt <= (PLL_SETTLE + 1) * MS_TICK_CYCLES + 4;
  endproperty
  property p_free_off;
    !ext_clk_expected |-> ##[1:2] pwm_free_run;
  endproperty
  property p_free_stuck;
    (ext_clk_expected && sync_cnt > SYNC_LOSS + 4) |-> pwm_free_run;
  endproperty
  property p_run_cause;
    s_run_start |-> !$past(chan_on_cmd[0]);
  endproperty
  property p_run_len;
    run_cnt <= (run_max + 2) * MS_TICK_CYCLES;
  endproperty
  property p_off_len;
    off_cnt <= (int'(off_delay_ms[0]) + int'(fall_ms[0]) + 2) * MS_TICK_CYCLES;
  endproperty
  a_busy_pulse: assert property (p_busy_pulse)
    else $error("busy fault longer than one cycle");
  a_busy_keep: assert property (p_busy_keep)
    else $error("stored value changed after busy");
  a_pll_on: assert property (p_pll_on)
    else $error("no unlocked status after frequency change");
  a_pll_len: assert property (p_pll_len)
    else $error("unlocked status too long");
  a_free_off: assert property (p_free_off)
    else $error("no free run without external clock");
  a_free_stuck: assert property (p_free_stuck)
    else $error("no free run on stuck sync");
  a_run_cause: assert property (p_run_cause)
    else $error("run pulse without off command");
  a_run_len: assert property (p_run_len)
    else $error("run pulse too long");
  a_off_len: assert property (p_off_len)
    else $error("output stays on too long after off");
endmodule // pcc_config_asserts
bind pcc_config pcc_config_asserts #(.MS_TICK_CYCLES(MS_TICK_CYCLES), .SYNC_LOSS(SYNC_LOSS),
  .PLL_SETTLE(PLL_SETTLE)) u_chk (.clock, .rst_b, .chan_on_cmd, .off_delay_ms, .fall_ms,
  .restart_ms, .sync_i, .ext_clk_expected, .chan_out_en, .run_oe_b, .pwm_freq_khz,
  .pwm_free_run, .pll_unlocked, .busy_fault, .phase_arrangement_byte);

/* pcc_config_test.sv */
`timescale 1ns/1ns
module pcc_config_test;
  import pcc_pkg::*;
  localparam int MT = 25;
  logic clock, rst_b, scl, sda, sda_o, sda_oe_b, shared_timebase_line_i, ext_clk_expected, ack;
  logic pwm_free_run, pll_unlocked, busy_fault, sense_is_drv_mon, sync_run;
  logic sync_i = 1'b0;
  logic [NUM_CH-1:0] chan_on_cmd, chan_out_en, run_o, run_oe_b;
  logic [NUM_CH-1:0][15:0] off_delay_ms, fall_ms, restart_ms;
  logic [10:0] pwm_freq_khz;
  logic [7:0] phase_arrangement_byte;
  logic [15:0] rd, w;
  logic [31:0] rng;
  int num_errors = 0, cmp_count = 0, busy_seen = 0, b0, exp_freq;

  pcc_config #(.MS_TICK_CYCLES(MT), .SYNC_LOSS(20), .PLL_SETTLE(2)) uut (.clock, .rst_b,
    .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_b, .chan_on_cmd, .off_delay_ms, .fall_ms,
    .restart_ms, .shared_timebase_line_i, .sync_i, .ext_clk_expected, .chan_out_en, .run_o, .run_oe_b,
    .pwm_freq_khz, .pwm_free_run, .pll_unlocked, .busy_fault, .sense_is_drv_mon,
    .phase_arrangement_byte);
  pcc_host_model host (.clock, .sda_oe_b, .scl, .sda);

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(negedge clock) if (sync_run) sync_i <= ~sync_i;
  always @(negedge clock) if (busy_fault === 1'b1) busy_seen <= busy_seen + 1;

  // ****************
  // helpers and model
  // ****************
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic int dec(input logic [15:0] v);
    int m, e;
    m = $signed(v[10:0]);
    e = $signed(v[15:11]);
    return (e < 0) ? (m >>> -e) : (m << e);
  endfunction
  // first ms tick may come early, so allow one ms either way
  function automatic logic near(input int cnt, input int ms);
    return (ms == 0) ? (cnt == 0) : (cnt >= (ms - 1) * MT && cnt <= (ms + 1) * MT + 4);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    cmp_count++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: %s saw %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic results();
    $display("counts: %0d compares, %0d mismatches", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic row(input logic [7:0] opt, input bit reon, input int rs);
    int lo, hi, dark, run_ms;
    restart_ms[0] = 16'(rs);
    host.wr(CMD_CHAN_OPT, '{opt}, ack);
    chan_on_cmd[0] = 1'b1;
    repeat (8) @(negedge clock);
    check(chan_out_en[0], 1'b1, "on");
    shared_timebase_line_i = 1'b0;
    repeat (8) @(negedge clock);
    check(chan_out_en[0], !opt[2], "share guard");
    shared_timebase_line_i = 1'b1;
    repeat (8) @(negedge clock);
    chan_on_cmd[0] = 1'b0;
    lo = 0;
    hi = 0;
    dark = 0;
    for (int i = 0; i < 260 * MT; i++) begin
      @(negedge clock);
      if (reon && i == MT) chan_on_cmd[0] = 1'b1;
      if (reon && i == MT + 6) check(chan_out_en[0], !opt[3], "abort");
      lo += (run_oe_b[0] === 1'b0);
      hi += (chan_out_en[0] === 1'b1);
      dark += (chan_out_en[0] === 1'b0);
    end
    run_ms = opt[4] ? 0 : ((141 > rs) ? 141 : rs);
    check(near(lo, run_ms), 1'b1, "run pulse");
    if (!reon) check(near(hi, 5), 1'b1, "off delay");
    else check(near(dark, opt[3] ? ((run_ms > 121) ? run_ms - 1 : 120) : 0), 1'b1, "hold");
    $display("done: row %h", opt);
  endtask

  initial begin
    rng = 32'd91788;
    rst_b = 1'b0;
    chan_on_cmd = '0;
    shared_timebase_line_i = 1'b1;
    ext_clk_expected = 1'b0;
    sync_run = 1'b0;
    off_delay_ms = {16'h0000, 16'h0003};
    fall_ms = {16'h0000, 16'h0002};
    restart_ms = '0;
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    check(pwm_freq_khz, FREQ_KHZ_RST, "freq rst");
    check(phase_arrangement_byte, PHASE_RST, "phase rst");
    check(sense_is_drv_mon, OPT_RST[5], "sense rst");
    check(pwm_free_run, 1'b1, "free no ext");
    check({sda_o, run_o}, 3'h0, "drive low");
    host.rd(CMD_FREQ, rd);
    check(rd, FREQ_RST, "freq rd rst");
    $display("done: reset");
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? {5'h1f, 11'd500} : (i == 1) ? {5'h01, 11'd500} :
          {5'h00, 11'(250 + xs() % 751)};
      host.wr(CMD_FREQ, '{w[7:0], w[15:8]}, ack);
      exp_freq = dec(w);
      check(ack, 1'b1, "freq ack");
      check(pwm_freq_khz, 16'(exp_freq), "freq");
      check(pll_unlocked, 1'b1, "pll");
      host.rd(CMD_FREQ, rd);
      check(rd, w, "freq rd");
      check(pll_unlocked, 1'b0, "pll settled");
    end
    host.wr(CMD_FREQ, '{8'h00}, ack);
    check(pwm_freq_khz, 16'(exp_freq), "lone byte");
    $display("done: frequency");
    host.wr(CMD_PAGE, '{8'h00}, ack);
    host.wr(CMD_CHAN_OPT, '{8'h3d}, ack);
    check(sense_is_drv_mon, 1'b1, "sense page0");
    host.wr(CMD_PAGE, '{8'h01}, ack);
    host.wr(CMD_CHAN_OPT, '{8'h1d}, ack);
    check(sense_is_drv_mon, 1'b1, "sense page1");
    host.wr(CMD_PAGE, '{8'h00}, ack);
    host.wr(CMD_CHAN_OPT, '{8'h1d}, ack);
    check(sense_is_drv_mon, 1'b0, "sense back");
    host.rd(CMD_CHAN_OPT, rd);
    check(rd[7:0], 8'h1d, "opt rd");
    $display("done: options");
    for (int c = 0; c < NUM_CH; c++) begin
      chan_on_cmd = 2'(1 << c);
      repeat (8) @(negedge clock);
      b0 = busy_seen;
      host.wr(CMD_FREQ, '{8'hf4, 8'h01}, ack);
      check(ack, 1'b0, "busy nack");
      host.wr(CMD_PHASE, '{8'h07}, ack);
      check(ack, 1'b0, "busy nack phase");
      check(16'(busy_seen - b0), 16'd2, "busy count");
      check(pwm_freq_khz, 16'(exp_freq), "kept freq");
      check(phase_arrangement_byte, PHASE_RST, "kept phase");
    end
    chan_on_cmd = '0;
    repeat (8 * MT) @(negedge clock);
    host.wr(CMD_PHASE, '{8'h07}, ack);
    check(phase_arrangement_byte, 8'h07, "phase");
    host.rd(CMD_PHASE, rd);
    check(rd[7:0], 8'h07, "phase rd");
    $display("done: busy");
    ext_clk_expected = 1'b1;
    sync_run = 1'b1;
    repeat (40) @(negedge clock);
    check(pwm_free_run, 1'b0, "locked");
    sync_run = 1'b0;
    repeat (40) @(negedge clock);
    check(pwm_free_run, 1'b1, "stuck");
    sync_run = 1'b1;
    $display("done: timebase");
    row(8'h05, 1'b0, 10);
    row(8'h11, 1'b0, 200);
    row(8'h0d, 1'b1, 200);
    row(8'h19, 1'b1, 10);
    row(8'h05, 1'b1, 10);
    results();
  end

  initial begin
    repeat (80000) @(posedge clock);
    num_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    results();
  end
endmodule // pcc_config_test

/* pcc_host_model.sv */
`timescale 1ns/1ns
module pcc_host_model #(
  parameter logic [6:0] ADDR = 7'h40
) (
  // clock
  input wire logic clock,
  // bus pins
  input wire logic sda_oe_b,
  output logic scl,
  output logic sda
);
  logic drv_low;
  // pull-up: line is high unless someone pulls it
  assign sda = !(drv_low || !sda_oe_b);
  initial begin
    scl = 1'b1;
    drv_low = 1'b0;
  end

  // ****************
  // bus cycles
  // ****************
  task automatic q();
    repeat (2) @(negedge clock);
  endtask
  task automatic start();
    q();
    drv_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    drv_low = 1'b1;
    q();
    scl = 1'b0;
  endtask
  task automatic stop();
    q();
    drv_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    drv_low = 1'b0;
  endtask
  // sample late in the high phase, well after the answer settles
  task automatic bit_io(input logic b, output logic r);
    q();
    drv_low = !b;
    q();
    scl = 1'b1;
    q();
    q();
    r = sda;
    scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d[$], output logic cack);
    logic a;
    start();
    wbyte({ADDR, 1'b0}, a);
    wbyte(cmd, cack);
    foreach (d[i]) wbyte(d[i], a);
    stop();
  endtask
  task automatic rd(input logic [7:0] cmd, output logic [15:0] d);
    logic a;
    start();
    wbyte({ADDR, 1'b0}, a);
    wbyte(cmd, a);
    start();
    wbyte({ADDR, 1'b1}, a);
    rbyte(1'b0, d[7:0]);
    rbyte(1'b1, d[15:8]);
    stop();
  endtask
endmodule // pcc_host_model

/* pcc_pkg.sv */
package pcc_pkg;

  // ************************************************************
  // command codes and defaults
  // ************************************************************
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_FREQ = 8'h33;
  localparam logic [7:0] CMD_CHAN_OPT = 8'hd0;
  localparam logic [7:0] CMD_PHASE = 8'hf5;
  localparam logic [7:0] READ_FILL = 8'hff;

  localparam logic [15:0] FREQ_RST = 16'hfbe8;
  localparam logic [10:0] FREQ_KHZ_RST = 11'h1f4;
  localparam logic [7:0] OPT_RST = 8'h1d;
  localparam logic [7:0] PHASE_RST = 8'h03;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int OPT_DRV_MON_BIT = 5;
  localparam int OPT_NO_RUN_PULSE_BIT = 4;
  localparam int OPT_SHORT_CYC_BIT = 3;
  localparam int OPT_SHARE_GUARD_BIT = 2;
  localparam int L11_EXP_MSB = 15;
  localparam int L11_EXP_LSB = 11;
  localparam int L11_MANT_MSB = 10;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int SYNC_LOSS_NS = 10000;
  localparam int SYNC_LOSS_CYCLES = (CLK_HZ / 1_000_000) * SYNC_LOSS_NS / 1000;
  localparam int PLL_SETTLE_MS = 2;
  localparam logic [17:0] RUN_PAD_MS = 18'h00088;
  localparam logic [17:0] MIN_OFF_MS = 18'h00078;

  localparam int NUM_CH = 2;
  localparam int BYTE_BITS = 8;

  // ************************************************************
  // state types
  // ************************************************************
  typedef enum logic [3:0] {
    PCC_IDLE, PCC_ADDR, PCC_ADDR_ACK, PCC_CMD, PCC_CMD_ACK,
    PCC_WDATA, PCC_WDATA_ACK, PCC_RDATA, PCC_RDATA_ACK, PCC_IGNORE
  } pcc_bus_t;

  typedef enum logic [2:0] {
    PCC_SQ_OFF, PCC_SQ_ON, PCC_SQ_DELAY, PCC_SQ_FALL, PCC_SQ_HOLD
  } pcc_seq_t;

  typedef struct packed {
    pcc_seq_t st;
    logic [17:0] tmr;
    logic [17:0] run_tmr;
    logic out_en;
    logic run_oe_b;
    logic operating;
  } pcc_seq_state_t;

endpackage
